// ### core/thermal_client_pkg.sv
// types for the thermal status client
// assumes nothing beyond the constants header
package thermal_client_pkg;

    // ======================================================
    // link sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_REF  = 5'h02,
        ST_RX   = 5'h04,
        ST_TX   = 5'h08,
        ST_DONE = 5'h10
    } link_state_t;

    typedef logic [15:0] reading_t;

endpackage

// ### core/thermal_client_regs.svh
// constants for the thermal status client: address, commands, codes, timing
// assumes a 200 MHz core clock and a host that sets the bit time per frame
`ifndef THERMAL_CLIENT_REGS_SVH
`define THERMAL_CLIENT_REGS_SVH

// ==========================================================
// link addressing and commands
`define CLIENT_ADDR        8'h30
`define CMD_READ_TEMP      8'h01
`define CMD_READ_THRESHOLD 8'h02
`define FRAME_BITS         5'h10
`define LAST_TX_BIT        5'h0F

// ==========================================================
// reply codes and temperature limits
`define ERR_SENSOR         16'h8000
`define ERR_UNDERFLOW      16'h8002
`define THRESHOLD_MAX      8'h1E
`define ACTIVATION_TEMP    8'h64

// ==========================================================
// timing: slowest bit rate in bits per second and derived cycle count
`define CLK_HZ             200000000
`define MIN_RATE_BPS       2000
`define MAX_BIT_CYCLES     (`CLK_HZ / `MIN_RATE_BPS)

`endif

// ### core/thermal_status_client.sv
// thermal status client: single-wire reply path, reading and threshold logic
// assumes sensor inputs come from logic on ref_clk_i; the wire comes from a pin
//
// Notes on behaviour
// - answer only frames addressed to 30h
// - link silent after reset until firmware enables
// - reading counts below activation point toward zero
// - control circuit active at count zero while the sensor is valid and fault-free
// - 8000h on sensor failure, 8002h on underflow
// - readings flagged invalid before and during reset
// - every addressed request gets an answer when enabled
// - threshold unsigned, reading negative, same format
// - threshold calibrated per part, readable by software
// - threshold held within 00h to 1Eh
// - overheat indicator asserted at maximum temperature
`include "thermal_client_regs.svh"

module thermal_status_client #(
    parameter int unsigned MAX_BIT_CYCLES = `MAX_BIT_CYCLES
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      wire_i,
    input  wire logic                      link_enable_i,
    input  wire logic                      sensor_valid_i,
    input  wire logic                      sensor_fault_i,
    input  wire logic                      sensor_underflow_i,
    input  wire logic [7:0]                die_temp_i,
    input  wire logic [7:0]                calib_fuse_i,
    output logic                           wire_o,
    output logic                           wire_oe_o,
    output logic                           overheat_indicator_o,
    output logic                           thermal_control_circuit_o,
    output logic [7:0]                     fan_control_threshold_o,
    output logic                           data_valid_o,
    output thermal_client_pkg::reading_t   last_reply_o
);
    import thermal_client_pkg::*;

    // ======================================================
    // wire input synchroniser and filter
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        line;
    logic        line_q;
    logic        rise;
    logic        fall;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= wire_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            line   <= 1'b0;
            line_q <= 1'b0;
        end else begin
            if (sync2 == sync3) begin
                line <= sync3;
            end
            line_q <= line;
        end
    end

    assign rise = line & ~line_q;
    assign fall = ~line & line_q;

    // ======================================================
    // firmware enable
    logic        en;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            en <= 1'b0;
        end else begin
            en <= link_enable_i;
        end
    end

    // ======================================================
    // reading path
    logic [7:0]  delta;
    logic        valid_q;
    logic        fault_q;
    logic        under_q;
    reading_t    temp_word;
    reading_t    thr_word;
    reading_t    reply;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            delta   <= 8'h00;
            valid_q <= 1'b0;
            fault_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            delta   <= (die_temp_i < `ACTIVATION_TEMP) ?
                       (`ACTIVATION_TEMP - die_temp_i) : 8'h00;
            valid_q <= sensor_valid_i;
            fault_q <= sensor_fault_i;
            under_q <= sensor_underflow_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            thermal_control_circuit_o <= 1'b0;
            overheat_indicator_o      <= 1'b0;
            data_valid_o              <= 1'b0;
        end else begin
            thermal_control_circuit_o <= valid_q & ~fault_q & (delta == 8'h00);
            overheat_indicator_o      <= valid_q & ~fault_q & (delta == 8'h00);
            data_valid_o              <= valid_q & ~fault_q & ~under_q;
        end
    end

    // reading sent as a negative offset, threshold as unsigned
    assign temp_word = 16'h0000 - {8'h00, delta};
    assign thr_word  = {8'h00, fan_control_threshold_o};

    // ======================================================
    // calibrated threshold, caught after reset release
    logic        caught;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            caught                  <= 1'b0;
            fan_control_threshold_o <= 8'h00;
        end else if (!caught) begin
            caught                  <= 1'b1;
            fan_control_threshold_o <= (calib_fuse_i > `THRESHOLD_MAX) ?
                                       `THRESHOLD_MAX : calib_fuse_i;
        end
    end

    // ======================================================
    // link sequencer
    link_state_t state;
    logic [19:0] cnt;
    logic [19:0] ref_w;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0]  bit_cnt;
    logic [19:0] half_w;
    logic [19:0] period_w;
    logic [19:0] hi_w;
    logic [19:0] timeout_w;
    logic [19:0] next_cnt;
    logic        frame_done;
    logic        addr_ok;

    assign half_w     = {1'b0, ref_w[19:1]};
    assign period_w   = {ref_w[18:0], 1'b0};
    assign hi_w       = tx_shift[15] ? (ref_w + half_w) : half_w;
    assign timeout_w  = {ref_w[17:0], 2'b00};
    assign next_cnt   = (cnt == period_w - 20'h00001) ? 20'h00000 : cnt + 20'h00001;
    assign frame_done = (state == ST_RX) && (bit_cnt == `FRAME_BITS);
    assign addr_ok    = (rx_shift[15:8] == `CLIENT_ADDR);

    always_comb begin
        if (fault_q || !valid_q) begin
            reply = `ERR_SENSOR;
        end else if (under_q) begin
            reply = `ERR_UNDERFLOW;
        end else if (rx_shift[7:0] == `CMD_READ_TEMP) begin
            reply = temp_word;
        end else if (rx_shift[7:0] == `CMD_READ_THRESHOLD) begin
            reply = thr_word;
        end else begin
            reply = `ERR_SENSOR;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state        <= ST_IDLE;
            cnt          <= 20'h00000;
            ref_w        <= 20'h00000;
            rx_shift     <= 16'h0000;
            tx_shift     <= 16'h0000;
            bit_cnt      <= 5'h00;
            wire_o       <= 1'b0;
            wire_oe_o    <= 1'b0;
            last_reply_o <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    wire_o    <= 1'b0;
                    wire_oe_o <= 1'b0;
                    if (rise) begin
                        state <= ST_REF;
                        cnt   <= 20'h00001;
                    end
                end
                ST_REF: begin
                    if (fall) begin
                        ref_w   <= cnt;
                        cnt     <= 20'h00000;
                        bit_cnt <= 5'h00;
                        state   <= ST_RX;
                    end else if (cnt >= MAX_BIT_CYCLES[19:0]) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 20'h00001;
                    end
                end
                ST_RX: begin
                    if (frame_done) begin
                        cnt     <= 20'h00000;
                        bit_cnt <= 5'h00;
                        if (addr_ok && en) begin
                            state        <= ST_TX;
                            tx_shift     <= reply;
                            last_reply_o <= reply;
                            wire_o       <= 1'b1;
                            wire_oe_o    <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (fall) begin
                        rx_shift <= {rx_shift[14:0], (cnt > half_w)};
                        bit_cnt  <= bit_cnt + 5'h01;
                        cnt      <= 20'h00000;
                    end else if (rise) begin
                        cnt <= 20'h00001;
                    end else if (cnt > timeout_w) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 20'h00001;
                    end
                end
                ST_TX: begin
                    cnt <= next_cnt;
                    if (next_cnt == 20'h00000) begin
                        tx_shift <= {tx_shift[14:0], 1'b0};
                        bit_cnt  <= bit_cnt + 5'h01;
                        if (bit_cnt == `LAST_TX_BIT) begin
                            state     <= ST_DONE;
                            wire_o    <= 1'b0;
                            wire_oe_o <= 1'b0;
                        end else begin
                            wire_o <= 1'b1;
                        end
                    end else begin
                        wire_o <= (next_cnt < hi_w);
                    end
                end
                ST_DONE: begin
                    if (rise) begin
                        cnt <= 20'h00000;
                    end else if (cnt >= period_w) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 20'h00001;
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    wire_o    <= 1'b0;
                    wire_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================
    // assertions
    a_quiet_after_reset: assert property (@(posedge ref_clk_i)
        reset_i |=> (state == ST_IDLE) && !wire_oe_o && !data_valid_o)
        else $error("link not quiet after reset");

    a_disabled_silent: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (frame_done && !en) |=> (state == ST_IDLE) && !wire_oe_o)
        else $error("answered while disabled");

    a_foreign_addr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (frame_done && (rx_shift[15:8] != `CLIENT_ADDR)) |=> !wire_oe_o)
        else $error("answered a foreign address");

    a_answer_all: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (frame_done && addr_ok && en) |=> (state == ST_TX) && wire_oe_o && wire_o
        && (last_reply_o == $past(reply)))
        else $error("addressed request not answered");

    a_count_down: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (die_temp_i < `ACTIVATION_TEMP) |=> (delta == `ACTIVATION_TEMP - $past(die_temp_i)))
        else $error("relative count wrong");

    a_ctrl_at_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (valid_q && !fault_q) |=> (thermal_control_circuit_o == ($past(delta) == 8'h00)))
        else $error("control circuit not tied to zero count");

    a_overheat_ctrl: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        overheat_indicator_o == thermal_control_circuit_o)
        else $error("overheat indicator disagrees");

    a_error_codes: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (frame_done && addr_ok && en && valid_q && !fault_q && under_q)
        |=> (last_reply_o == `ERR_UNDERFLOW))
        else $error("underflow code missing");

    a_error_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (frame_done && addr_ok && en && fault_q) |=> (tx_shift == `ERR_SENSOR))
        else $error("fault reply not the error code");

    a_thr_range: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        fan_control_threshold_o <= `THRESHOLD_MAX)
        else $error("threshold out of range");

    a_thr_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (caught && $past(caught)) |-> $stable(fan_control_threshold_o))
        else $error("threshold changed after capture");

    c_answered: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        (state == ST_TX) ##1 (state == ST_DONE));
    c_fault_reply: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        frame_done && addr_ok && en && fault_q);
    c_ctrl_on: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(thermal_control_circuit_o));
    c_foreign: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        frame_done && !addr_ok);

endmodule

// ### tb/thermal_host_model.sv
// host controller model for the single-wire thermal link
// assumes wire_i is the resolved line level, pulled low when nobody drives
module thermal_host_model #(
    parameter int R = 40
) (
    input  wire logic ref_clk_i,
    input  wire logic wire_i,
    input  wire logic client_oe_i,
    output logic      drive_o,
    output logic      protect_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int misses;

    // ==========================================================
    // safe default until a valid reading arrives
    initial begin
        drive_o = 1'b0;
        protect_o = 1'b1;
        misses = 3;
    end

    task automatic pulse(input int hi, input int lo);
        drive_o = 1'b1;
        repeat (hi) @(negedge ref_clk_i);
        drive_o = 1'b0;
        repeat (lo) @(negedge ref_clk_i);
    endtask

    // ==========================================================
    // one request frame and its reply; bit time 2R set by the host
    task automatic transact(input logic [7:0] a, input logic [7:0] c,
                            output logic [15:0] rep, output logic ok);
        logic [15:0] word;
        int n;
        word = {a, c};
        rep = 16'h0000;
        ok = 1'b0;
        pulse(R, R);
        for (int i = 15; i >= 0; i--)
            pulse(word[i] ? R - R / 8 : R / 5,
                  (i == 0) ? 0 : (word[i] ? R + R / 8 : 2 * R - R / 5));
        // the reply is timed from the moment the client takes the wire
        n = 0;
        while (!client_oe_i && n < 8 * R) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (client_oe_i) begin
            ok = 1'b1;
            repeat (R) @(negedge ref_clk_i);
            for (int k = 15; k >= 0; k--) begin
                rep[k] = wire_i;
                if (k > 0) repeat (2 * R) @(negedge ref_clk_i);
            end
        end
        // three misses in a row call for protective action
        misses = (ok && rep !== 16'h8000 && rep !== 16'h8002) ? 0 : misses + 1;
        protect_o = (misses >= 3);
        repeat (4 * R) @(negedge ref_clk_i);
    endtask
endmodule

// ### tb/thermal_status_client_tb_top.sv
// self-checking bench for the thermal status client
// assumes the host model drives the wire and the line idles low
`include "thermal_client_regs.svh"

module thermal_status_client_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import thermal_client_pkg::*;

    logic       ref_clk_i, reset_i, link_enable_i, sensor_valid_i;
    logic       sensor_fault_i, sensor_underflow_i;
    logic [7:0] die_temp_i, calib_fuse_i, thr;
    logic       wire_o, wire_oe_o, hot, ctrl_active, data_valid, drive, protect;
    reading_t   last_reply;
    wire        line = (wire_oe_o & wire_o) | drive;
    int         failures = 0;
    int         check_count = 0;

    thermal_status_client #(.MAX_BIT_CYCLES(200)) DUT (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wire_i(line),
        .link_enable_i(link_enable_i), .sensor_valid_i(sensor_valid_i),
        .sensor_fault_i(sensor_fault_i), .sensor_underflow_i(sensor_underflow_i),
        .die_temp_i(die_temp_i), .calib_fuse_i(calib_fuse_i), .wire_o(wire_o),
        .wire_oe_o(wire_oe_o), .overheat_indicator_o(hot),
        .thermal_control_circuit_o(ctrl_active), .fan_control_threshold_o(thr),
        .data_valid_o(data_valid), .last_reply_o(last_reply));

    thermal_host_model #(.R(40)) host (
        .ref_clk_i(ref_clk_i), .wire_i(line), .client_oe_i(wire_oe_o),
        .drive_o(drive), .protect_o(protect));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================================
    // shared checking
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic ask(input logic [7:0] a, input logic [7:0] c, input logic exp_ok,
                       input logic [15:0] exp, input string what);
        logic [15:0] rep;
        logic        ok;
        host.transact(a, c, rep, ok);
        check({what, " answered"}, {15'h0, ok}, {15'h0, exp_ok});
        if (exp_ok) begin
            check(what, rep, exp);
            check({what, " held"}, last_reply, exp);
        end
    endtask

    function automatic logic [15:0] exp_temp(input logic [7:0] d);
        return (d >= `ACTIVATION_TEMP) ? 16'h0000 : 16'h0000 - {8'h00, `ACTIVATION_TEMP - d};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_disabled;
        ask(`CLIENT_ADDR, `CMD_READ_TEMP, 1'b0, 16'h0000, "disabled");
        link_enable_i = 1'b1;
        $display("test disabled done");
    endtask

    task automatic t_threshold;
        check("threshold", {8'h00, thr}, {8'h00, `THRESHOLD_MAX});
        ask(`CLIENT_ADDR, `CMD_READ_THRESHOLD, 1'b1, 16'h001E, "thr read");
        check("thr degrees", 16'h0032 + {8'h00, thr}, 16'h0050);
        $display("test threshold done");
    endtask

    task automatic t_reading;
        logic [7:0] temps [5] = '{8'h10, 8'h63, 8'h64, 8'h70, 8'h00};
        logic       fan_on;
        foreach (temps[i]) begin
            die_temp_i = temps[i];
            ask(`CLIENT_ADDR, `CMD_READ_TEMP, 1'b1, exp_temp(temps[i]), "temp");
            check("hot", {15'h0, hot}, {15'h0, temps[i] >= 8'h64});
            check("ctrl", {15'h0, ctrl_active}, {15'h0, temps[i] >= 8'h64});
            fan_on = $signed(last_reply) > -$signed({8'h00, thr});
            check("fan", {15'h0, fan_on}, {15'h0, temps[i] > `ACTIVATION_TEMP - `THRESHOLD_MAX});
            check("valid", {15'h0, data_valid}, 16'h0001);
        end
        $display("test reading done");
    endtask

    task automatic t_errors;
        logic [18:0] cases [4] = '{{3'b110, 16'h8000}, {3'b101, 16'h8002},
                                   {3'b111, 16'h8000}, {3'b000, 16'h8000}};
        die_temp_i = 8'h64;
        foreach (cases[i]) begin
            {sensor_valid_i, sensor_fault_i, sensor_underflow_i} = cases[i][18:16];
            ask(`CLIENT_ADDR, `CMD_READ_TEMP, 1'b1, cases[i][15:0], "error");
            check("err hot", {15'h0, hot}, {15'h0, cases[i][18] & ~cases[i][17]});
            check("err valid", {15'h0, data_valid}, 16'h0000);
        end
        {sensor_valid_i, sensor_fault_i, sensor_underflow_i} = 3'b100;
        ask(`CLIENT_ADDR, 8'h07, 1'b1, `ERR_SENSOR, "unknown cmd");
        check("protect", {15'h0, protect}, 16'h0001);
        $display("test errors done");
    endtask

    task automatic t_foreign;
        die_temp_i = 8'h5A;
        ask(8'h31, `CMD_READ_TEMP, 1'b0, 16'h0000, "foreign");
        ask(`CLIENT_ADDR, `CMD_READ_TEMP, 1'b1, exp_temp(8'h5A), "own 1");
        check("protect off", {15'h0, protect}, 16'h0000);
        ask(`CLIENT_ADDR, `CMD_READ_TEMP, 1'b1, exp_temp(8'h5A), "own 2");
        $display("test foreign done");
    endtask

    task automatic t_recalib;
        reset_i = 1'b1;
        calib_fuse_i = 8'h00;
        repeat (16) @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check("thr low", {8'h00, thr}, 16'h0000);
        ask(`CLIENT_ADDR, `CMD_READ_THRESHOLD, 1'b1, 16'h0000, "thr low read");
        $display("test recalib done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        reset_i = 1'b1;
        link_enable_i = 1'b0;
        sensor_valid_i = 1'b1;
        sensor_fault_i = 1'b0;
        sensor_underflow_i = 1'b0;
        die_temp_i = 8'h64;
        calib_fuse_i = 8'h25;
        repeat (16) @(negedge ref_clk_i);
        check("reset hot", {15'h0, hot}, 16'h0000);
        check("reset valid", {15'h0, data_valid}, 16'h0000);
        reset_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        t_disabled();
        t_threshold();
        t_reading();
        t_errors();
        t_foreign();
        t_recalib();
        end_sim();
    end
endmodule
